// ==== rtl/bsce_exec.sv ====
// What this block does
// [RL1] Test ANDs register with itself, updates Z N V only, one cycle.
// [RL2] Compare-skip skips next instruction when registers equal, no flags.
// [RL3] Compare-immediate subtracts constant, sets Z N V C H, one cycle.
// [RL4] Register-bit skips skip next when chosen bit clear or set.
// [RL5] I/O-bit skips skip next when chosen I/O bit clear or set.
// [RL6] Generic flag branches jump to PC+offset+1 on chosen flag state.
// [RL7] Equal branch taken on Z one, not-equal on Z zero.
// [RL8] Carry set and lower branch on C one; clear, same or higher on C zero.
// [RL9] Signed branches use N xor V: ge on zero, lt on one.
// [RL10] Half-carry branches taken on H one or zero, one or two cycles.
// [RL11] T branches taken on T one or zero, flags untouched.
// [RL12] Overflow branch taken when V is one, one or two cycles.
// [RL13] Minus branch taken on N one, plus branch on N zero.
// [RL14] Fractional multiply puts product shifted left into R1:R0, Z and C.
// [RL15] Indirect jump loads PC from Z pair, two cycles, no flags.
// [RL16] Indirect call loads PC from Z pair, three cycles, no flags.
// [RL17] Skips add two or three to PC, one cycle per skipped word.
// [RL18] Calls push the return address; returns pop it into PC.
`timescale 1ns/1ns
module bsce_exec
	import bsce_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int STACK_DEPTH = 16
)(
	input wire logic SYS_CLK, // Core clock, 50 MHz.
	input wire logic RST_N, // Asynchronous reset, active low.
	input wire logic [15:0] INSTR, // Program word at PROG_ADDR.
	input wire logic [255:0] IO_REGS, // Bit-addressable I/O space.
	input wire logic [4:0] DBG_REG_SEL, // Working register to observe.
	output logic [PC_W-1:0] PROG_ADDR, // Program counter.
	output logic [7:0] STATUS_FLAGS, // Status flags.
	output logic [7:0] DBG_REG_DATA, // Selected working register.
	output logic EXEC_BUSY // High while a multi-cycle op runs.
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	// Refuse sizes that the fetch path and the stack pointer cannot serve.
	if (PC_W < 8 || PC_W > 16 || STACK_DEPTH < 2 ||
		(1 << SP_W) != STACK_DEPTH)
	begin : g_bad_size
		$error("bsce_exec: unsupported PC_W or STACK_DEPTH");
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic flag_branch(input logic [5:0] op,
		input logic [2:0] sel, input logic [7:0] f);
		logic t;
		t = 1'b0;
		case (op)
			OP_BR_FLAG_SET: t = f[sel]; // [RL6]
			OP_BR_FLAG_CLR: t = !f[sel]; // [RL6]
			OP_BR_EQ: t = f[FL_Z]; // [RL7]
			OP_BR_NE: t = !f[FL_Z]; // [RL7]
			OP_BR_CS, OP_BR_LO: t = f[FL_C]; // [RL8]
			OP_BR_CC, OP_BR_SH: t = !f[FL_C]; // [RL8]
			OP_BR_GE: t = !(f[FL_N] ^ f[FL_V]); // [RL9]
			OP_BR_LT: t = f[FL_N] ^ f[FL_V]; // [RL9]
			OP_BR_HS: t = f[FL_H]; // [RL10]
			OP_BR_HC: t = !f[FL_H]; // [RL10]
			OP_BR_TS: t = f[FL_T]; // [RL11]
			OP_BR_TC: t = !f[FL_T]; // [RL11]
			OP_BR_VS: t = f[FL_V]; // [RL12]
			OP_BR_MI: t = f[FL_N]; // [RL13]
			OP_BR_PL: t = !f[FL_N]; // [RL13]
			default: t = 1'b0;
		endcase
		return t;
	endfunction : flag_branch

	function automatic logic is_branch(input logic [5:0] op);
		return op >= OP_BR_FLAG_SET && op <= OP_BR_VS;
	endfunction : is_branch

	// The skipped word's length decides the extra cycle count.
	function automatic logic is_two_word(input logic [15:0] w);
		return w[OP_MSB:OP_LSB] == OP_LONG &&
			w[PFX_MSB] == 1'b0;
	endfunction : is_two_word

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	bsce_state_t state_reg, state_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [7:0] flags_reg, flags_next;
	logic [2:0] wait_reg, wait_next;
	logic [SP_W-1:0] sp_reg, sp_next;
	logic [7:0] dbg_reg, dbg_next;
	logic busy_reg, busy_next;
	logic [7:0] regs_reg [32];
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];

	logic wr_en, wr2_en, push_en;
	logic [4:0] wr_addr;
	logic [7:0] wr_data, wr2_data;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	logic [5:0] op;
	logic [4:0] rd_a, rr_a;
	logic [7:0] rd_v, rr_v, imm, hi_v, diff;
	logic [2:0] bsel;
	logic [PC_W-1:0] pc_inc, br_target, z_ptr;
	logic [17:0] prod;
	logic [15:0] fprod;
	logic pfx_cmp, pfx_ld;

	always_comb
	begin
		op = INSTR[OP_MSB:OP_LSB];
		pfx_cmp = INSTR[PFX_MSB:PFX_LSB] == PFX_CMP_IMM;
		pfx_ld = INSTR[PFX_MSB:PFX_LSB] == PFX_LOAD_IMM;
		rd_a = INSTR[RD_MSB:RD_LSB];
		rr_a = INSTR[RR_MSB:RR_LSB];
		bsel = INSTR[BIT_MSB:0];
		rd_v = regs_reg[rd_a];
		rr_v = regs_reg[rr_a];
		imm = INSTR[IMM_MSB:0];
		hi_v = regs_reg[{1'b1, INSTR[RH_MSB:RH_LSB]}];
		diff = hi_v - imm;
		pc_inc = pc_reg + 1'b1;
		br_target = pc_inc + PC_W'($signed(INSTR[OFS_MSB:0]));
		z_ptr = PC_W'({regs_reg[31], regs_reg[30]});
		prod = 18'($signed({rd_v[7], rd_v}) * $signed({1'b0, rr_v}));
		fprod = prod[15:0];
	end

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		pc_next = pc_reg;
		flags_next = flags_reg;
		wait_next = wait_reg;
		sp_next = sp_reg;
		wr_en = 1'b0;
		wr2_en = 1'b0;
		push_en = 1'b0;
		wr_addr = 5'h00;
		wr_data = 8'h00;
		wr2_data = 8'h00;
		case (state_reg)
			ST_EXEC:
			begin
				pc_next = pc_inc;
				if (pfx_cmp)
				begin
					// Result is discarded; only flags change.
					flags_next[FL_Z] = diff == 8'h00; // [RL3]
					flags_next[FL_N] = diff[7]; // [RL3]
					flags_next[FL_C] = imm > hi_v; // [RL3]
					flags_next[FL_V] = (hi_v[7] & ~imm[7] & ~diff[7]) |
						(~hi_v[7] & imm[7] & diff[7]); // [RL3]
					flags_next[FL_H] = (~hi_v[3] & imm[3]) |
						(imm[3] & diff[3]) | (diff[3] & ~hi_v[3]); // [RL3]
					flags_next[FL_S] = flags_next[FL_N] ^ flags_next[FL_V];
				end
				else if (pfx_ld)
				begin
					wr_en = 1'b1;
					wr_addr = {1'b1, INSTR[RH_MSB:RH_LSB]};
					wr_data = imm;
				end
				else if (is_branch(op))
				begin
					if (flag_branch(op, INSTR[SEL_MSB:SEL_LSB], flags_reg))
					begin
						pc_next = br_target; // [RL6]
						wait_next = 3'(CYC_BRANCH_TAKEN - 1'b1);
						state_next = ST_WAIT;
					end
				end
				else
				begin
					case (op)
						OP_TEST:
						begin
							// The register keeps its value.
							flags_next[FL_Z] = rd_v == 8'h00; // [RL1]
							flags_next[FL_N] = rd_v[7]; // [RL1]
							flags_next[FL_V] = 1'b0; // [RL1]
						end
						OP_CMP_SKIP:
							if (rd_v == rr_v)
								state_next = ST_SKIP; // [RL2]
						OP_SKIP_RB_CLR:
							if (!rd_v[bsel])
								state_next = ST_SKIP; // [RL4]
						OP_SKIP_RB_SET:
							if (rd_v[bsel])
								state_next = ST_SKIP; // [RL4]
						OP_SKIP_IO_CLR:
							if (!IO_REGS[{rd_a, bsel}])
								state_next = ST_SKIP; // [RL5]
						OP_SKIP_IO_SET:
							if (IO_REGS[{rd_a, bsel}])
								state_next = ST_SKIP; // [RL5]
						OP_FMUL_SU:
						begin
							wr_en = 1'b1;
							wr2_en = 1'b1;
							wr_addr = 5'h00;
							wr_data = {fprod[6:0], 1'b0}; // [RL14]
							wr2_data = fprod[14:7]; // [RL14]
							flags_next[FL_C] = fprod[15]; // [RL14]
							flags_next[FL_Z] = fprod[14:0] == 15'h0000; // [RL14]
							wait_next = 3'(CYC_FMUL - 1'b1);
							state_next = ST_WAIT;
						end
						OP_IND_JUMP:
						begin
							pc_next = z_ptr; // [RL15]
							wait_next = 3'(CYC_IND_JUMP - 1'b1);
							state_next = ST_WAIT;
						end
						OP_IND_CALL:
						begin
							push_en = 1'b1; // [RL18]
							sp_next = sp_reg + 1'b1;
							pc_next = z_ptr; // [RL16]
							wait_next = 3'(CYC_IND_CALL - 1'b1);
							state_next = ST_WAIT;
						end
						OP_RETURN:
						begin
							sp_next = sp_reg - 1'b1;
							pc_next = stack_mem[sp_reg - 1'b1]; // [RL18]
							wait_next = CYC_RETURN - 1'b1;
							state_next = ST_WAIT;
						end
						OP_FLAG_WR:
							flags_next[bsel] = INSTR[FLAG_VAL_POS];
						OP_LONG:
							pc_next = pc_reg + 2'h2;
						default:
							pc_next = pc_inc;
					endcase
				end
			end
			ST_SKIP:
			begin
				// Word now on INSTR is the one being skipped.
				pc_next = pc_inc; // [RL17]
				state_next = is_two_word(INSTR) ? ST_SKIP2 : ST_EXEC; // [RL17]
			end
			ST_SKIP2:
			begin
				pc_next = pc_inc; // [RL17]
				state_next = ST_EXEC;
			end
			ST_WAIT:
			begin
				wait_next = wait_reg - 1'b1;
				if (wait_reg == 3'h1)
					state_next = ST_EXEC;
			end
			default:
				state_next = ST_EXEC;
		endcase
		dbg_next = regs_reg[DBG_REG_SEL];
		busy_next = state_next != ST_EXEC;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_reg <= ST_EXEC;
			pc_reg <= '0;
			flags_reg <= FLAGS_RST;
			wait_reg <= 3'h0;
			sp_reg <= '0;
			dbg_reg <= 8'h00;
			busy_reg <= 1'b0;
			for (int i = 0; i < 32; i++)
				regs_reg[i] <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			flags_reg <= flags_next;
			wait_reg <= wait_next;
			sp_reg <= sp_next;
			dbg_reg <= dbg_next;
			busy_reg <= busy_next;
			if (wr_en)
				regs_reg[wr_addr] <= wr_data;
			if (wr2_en)
				regs_reg[1] <= wr2_data;
		end
	end

	// Stack memory holds no reset so it can map onto plain RAM.
	always_ff @(posedge SYS_CLK)
	begin
		if (push_en)
			stack_mem[sp_reg] <= pc_inc; // [RL18]
	end

	assign PROG_ADDR = pc_reg;
	assign STATUS_FLAGS = flags_reg;
	assign DBG_REG_DATA = dbg_reg;
	assign EXEC_BUSY = busy_reg;

endmodule : bsce_exec

// ==== rtl/bsce_pkg.sv ====
package bsce_pkg;

	// ------------------------------------------------------------------
	// Instruction word fields
	// ------------------------------------------------------------------
	localparam int OP_MSB = 15;
	localparam int OP_LSB = 10;
	localparam int RD_MSB = 9;
	localparam int RD_LSB = 5;
	localparam int RR_MSB = 4;
	localparam int RR_LSB = 0;
	localparam int BIT_MSB = 2;
	localparam int SEL_MSB = 9;
	localparam int SEL_LSB = 7;
	localparam int OFS_MSB = 6;
	localparam int PFX_MSB = 15;
	localparam int PFX_LSB = 12;
	localparam int RH_MSB = 11;
	localparam int RH_LSB = 8;
	localparam int IMM_MSB = 7;
	localparam int FLAG_VAL_POS = 3;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [5:0] OP_TEST = 6'h01;
	localparam logic [5:0] OP_CMP_SKIP = 6'h02;
	localparam logic [5:0] OP_SKIP_RB_CLR = 6'h03;
	localparam logic [5:0] OP_SKIP_RB_SET = 6'h04;
	localparam logic [5:0] OP_SKIP_IO_CLR = 6'h05;
	localparam logic [5:0] OP_SKIP_IO_SET = 6'h06;
	localparam logic [5:0] OP_BR_FLAG_SET = 6'h08;
	localparam logic [5:0] OP_BR_FLAG_CLR = 6'h09;
	localparam logic [5:0] OP_BR_EQ = 6'h0a;
	localparam logic [5:0] OP_BR_NE = 6'h0b;
	localparam logic [5:0] OP_BR_CS = 6'h0c;
	localparam logic [5:0] OP_BR_CC = 6'h0d;
	localparam logic [5:0] OP_BR_SH = 6'h0e;
	localparam logic [5:0] OP_BR_LO = 6'h0f;
	localparam logic [5:0] OP_BR_MI = 6'h10;
	localparam logic [5:0] OP_BR_PL = 6'h11;
	localparam logic [5:0] OP_BR_GE = 6'h12;
	localparam logic [5:0] OP_BR_LT = 6'h13;
	localparam logic [5:0] OP_BR_HS = 6'h14;
	localparam logic [5:0] OP_BR_HC = 6'h15;
	localparam logic [5:0] OP_BR_TS = 6'h16;
	localparam logic [5:0] OP_BR_TC = 6'h17;
	localparam logic [5:0] OP_BR_VS = 6'h18;
	localparam logic [5:0] OP_FMUL_SU = 6'h19;
	localparam logic [5:0] OP_IND_JUMP = 6'h1a;
	localparam logic [5:0] OP_IND_CALL = 6'h1b;
	localparam logic [5:0] OP_RETURN = 6'h1c;
	localparam logic [5:0] OP_FLAG_WR = 6'h1d;
	localparam logic [5:0] OP_LONG = 6'h1e;
	localparam logic [3:0] PFX_CMP_IMM = 4'h8;
	localparam logic [3:0] PFX_LOAD_IMM = 4'h9;

	// ------------------------------------------------------------------
	// Status flag positions and reset value
	// ------------------------------------------------------------------
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// ------------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------------
	localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
	localparam logic [1:0] CYC_FMUL = 2'h2;
	localparam logic [1:0] CYC_IND_JUMP = 2'h2;
	localparam logic [1:0] CYC_IND_CALL = 2'h3;
	localparam logic [2:0] CYC_RETURN = 3'h4;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_SKIP = 2'b01,
		ST_SKIP2 = 2'b11,
		ST_WAIT = 2'b10
	} bsce_state_t;

endpackage : bsce_pkg

// ==== test/bsce_prog_mem.sv ====
`timescale 1ns/1ns
module bsce_prog_mem
#(
	parameter int PC_W = 16
)(
	input wire logic [PC_W-1:0] addr, // Fetch address.
	output logic [15:0] data // Word at addr, read without delay.
);
	// Only eight address bits decode, so far targets alias low words.
	logic [15:0] mem [256];
	assign data = mem[addr[7:0]];
endmodule : bsce_prog_mem

// ==== test/bsce_exec_asserts.sv ====
`timescale 1ns/1ns
module bsce_exec_asserts
	import bsce_pkg::*;
#(
	parameter int PC_W = 16
)(
	input wire logic SYS_CLK, // Core clock.
	input wire logic RST_N, // Reset, active low.
	input wire logic [15:0] INSTR, // Program word.
	input wire logic [255:0] IO_REGS, // I/O space.
	input wire logic [4:0] DBG_REG_SEL, // Observed register.
	input wire logic [PC_W-1:0] PROG_ADDR, // Program counter.
	input wire logic [7:0] STATUS_FLAGS, // Flags.
	input wire logic [7:0] DBG_REG_DATA, // Observed value.
	input wire logic EXEC_BUSY // Multi-cycle op running.
);
	logic [5:0] op;
	logic [PC_W-1:0] tgt;
	logic [3:0] kept;
	logic go;
	logic io_bit;
	assign op = INSTR[OP_MSB:OP_LSB];
	assign go = !EXEC_BUSY;
	assign tgt = PROG_ADDR + {{(PC_W-7){INSTR[6]}}, INSTR[6:0]} + 1'b1;
	assign kept = {STATUS_FLAGS[FL_S], STATUS_FLAGS[FL_T],
		STATUS_FLAGS[FL_H], STATUS_FLAGS[FL_C]};
	assign io_bit = IO_REGS[{INSTR[9:5], INSTR[2:0]}];
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_wait1;
		EXEC_BUSY ##1 !EXEC_BUSY;
	endsequence
	sequence s_wait2;
		EXEC_BUSY [*2] ##1 !EXEC_BUSY;
	endsequence
	chk_br_eq_taken: assert property (
		go && op == OP_BR_EQ && STATUS_FLAGS[FL_Z]
		|=> (PROG_ADDR == $past(tgt)) ##0 s_wait1) else $error("eq branch");
	chk_br_ne_held: assert property (
		go && op == OP_BR_NE && STATUS_FLAGS[FL_Z]
		|=> go && PROG_ADDR == $past(PROG_ADDR) + 1'b1)
		else $error("ne branch");
	chk_br_flags_kept: assert property (go &&
		op inside {[OP_BR_FLAG_SET:OP_BR_VS]} |=> $stable(STATUS_FLAGS))
		else $error("branch flags");
	chk_skip_io_set: assert property (
		go && op == OP_SKIP_IO_SET && io_bit
		|=> EXEC_BUSY && PROG_ADDR == $past(PROG_ADDR) + 1'b1)
		else $error("io skip");
	chk_test_flags: assert property (go && op == OP_TEST
		|=> go && $stable(kept) && !STATUS_FLAGS[FL_V]) else $error("test flags");
	chk_fmul_cycles: assert property (
		go && op == OP_FMUL_SU |=> s_wait1)
		else $error("fmul cycles");
	chk_indirect_jump_op_cycles: assert property (go && op == OP_IND_JUMP
		|=> $stable(STATUS_FLAGS) ##0 s_wait1) else $error("indirect_jump_op cycles");
	chk_indirect_call_op_cycles: assert property (
		go && op == OP_IND_CALL |=> s_wait2)
		else $error("indirect_call_op cycles");
endmodule : bsce_exec_asserts

bind bsce_exec bsce_exec_asserts #(.PC_W(PC_W)) u_chk (.SYS_CLK(SYS_CLK),
	.RST_N(RST_N), .INSTR(INSTR), .IO_REGS(IO_REGS), .DBG_REG_SEL(DBG_REG_SEL),
	.PROG_ADDR(PROG_ADDR), .STATUS_FLAGS(STATUS_FLAGS),
	.DBG_REG_DATA(DBG_REG_DATA), .EXEC_BUSY(EXEC_BUSY));

// ==== test/branch_skip_compare_exec_bench.sv ====
`timescale 1ns/1ns
module branch_skip_compare_exec_bench
	import bsce_pkg::*;
;
	localparam logic [5:0] BOPS [17] = '{OP_BR_EQ, OP_BR_NE, OP_BR_CS,
		OP_BR_CC, OP_BR_SH, OP_BR_LO, OP_BR_MI, OP_BR_PL, OP_BR_GE, OP_BR_LT,
		OP_BR_HS, OP_BR_HC, OP_BR_TS, OP_BR_TC, OP_BR_VS, OP_BR_FLAG_SET,
		OP_BR_FLAG_CLR};
	localparam logic [2:0] BFL [17] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h2, 3'h2, 3'h2, 3'h2, 3'h5, 3'h5, 3'h6, 3'h6, 3'h3, 3'h6, 3'h6};
	localparam bit BTV [17] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1,
		1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
	localparam logic [5:0] SOPS [5] = '{OP_SKIP_RB_CLR, OP_SKIP_RB_SET,
		OP_SKIP_IO_CLR, OP_SKIP_IO_SET, OP_CMP_SKIP};
	localparam bit SPOL [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [255:0] io = '0;
	logic [4:0] sel = 5'h00;
	logic [15:0] instr;
	logic [15:0] pc;
	logic [7:0] fl;
	logic [7:0] dbg;
	logic busy;
	int fail_count = 0;
	int n_compared = 0;
	bsce_exec dut (.SYS_CLK(clk), .RST_N(rst_n), .INSTR(instr), .IO_REGS(io),
		.DBG_REG_SEL(sel), .PROG_ADDR(pc), .STATUS_FLAGS(fl),
		.DBG_REG_DATA(dbg), .EXEC_BUSY(busy));
	bsce_prog_mem pm (.addr(pc), .data(instr));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Inputs change 1 ns after each rising edge, checks sit there too.
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	function automatic logic [15:0] ldi(logic [3:0] r, logic [7:0] k);
		return {PFX_LOAD_IMM, r, k};
	endfunction : ldi
	function automatic logic [15:0] ins(logic [5:0] o, logic [4:0] a,
		logic [4:0] b);
		return {o, a, b};
	endfunction : ins
	task automatic boot(logic [15:0] w0, logic [15:0] w1, logic [15:0] w2);
		rst_n = 1'b0;
		for (int i = 0; i < 256; i++)
			pm.mem[i] = 16'h0000;
		pm.mem[0] = w0;
		pm.mem[1] = w1;
		pm.mem[2] = w2;
		step(1);
		rst_n = 1'b1;
	endtask : boot
	task automatic t_branch;
		bit tk;
		for (int i = 0; i < 17; i++)
		begin
			for (int v = 0; v < 2; v++)
			begin
				tk = (v[0] == BTV[i]);
				boot(ins(OP_FLAG_WR, 5'h00, {1'b0, v[0], BFL[i]}),
					ins(BOPS[i], {BFL[i], 2'h3}, 5'h1d), 16'h0000);
				step(2);
				chk("branch pc", pc, tk ? 16'hffff : 16'h0002);
				chk("branch busy", 16'(busy), 16'(tk));
				chk("branch taken", 16'(busy), 16'(tk));
				step(1);
				chk("branch end", 16'(busy), 16'h0000);
			end
		end
	endtask : t_branch
	task automatic t_skip;
		int cyc;
		logic [4:0] a;
		logic [4:0] b;
		for (int i = 0; i < 5; i++)
		begin
			for (int c = 0; c < 4; c++)
			begin
				io = '0;
				io[26] = c[0];
				cyc = (c[0] == SPOL[i]) ? 2 + c[1] : 1;
				a = (i == 2 || i == 3) ? 5'h03 : 5'h10;
				b = (i == 4) ? (c[0] ? 5'h10 : 5'h11) : (i < 2 && !c[0]) ? 5'h03 : 5'h02;
				boot(ldi(4'h0, 8'h04), ins(SOPS[i], a, b),
					c[1] ? {OP_LONG, 10'h000} : 16'h0000);
				step(1 + cyc);
				chk("skip pc", pc, 16'(1 + cyc));
				chk("skip busy", 16'(busy), 16'h0000);
				chk("skip flags", 16'(fl), 16'(FLAGS_RST));
				if (cyc == 1 && c[1])
				begin
					// The unskipped long word runs as a two-word no-op.
					step(1);
					chk("long pc", pc, 16'h0004);
				end
			end
		end
	endtask : t_skip
	task automatic t_flags;
		boot(ldi(4'h0, 8'h80), ins(OP_FLAG_WR, 5'h00, {2'h1, 3'(FL_C)}),
			ins(OP_TEST, 5'h10, 5'h10));
		pm.mem[3] = {PFX_CMP_IMM, 4'h0, 8'h81};
		sel = 5'h10;
		step(3);
		chk("test flags", 16'(fl), 16'h0005);
		step(1);
		chk("cmp flags", 16'(fl), 16'h0035);
		chk("cmp pc", pc, 16'h0004);
		chk("cmp reg", 16'(dbg), 16'h0080);
	endtask : t_flags
	task automatic t_fmul;
		for (int n = 0; n < 2; n++)
		begin
			boot(ldi(4'h0, n ? 8'hc0 : 8'h40), ldi(4'h1, 8'h81),
				ins(OP_FMUL_SU, 5'h10, 5'h11));
			sel = 5'h01;
			step(3);
			chk("fmul busy", 16'(busy), 16'h0001);
			chk("fmul flags", 16'(fl), 16'(n));
			step(1);
			chk("fmul pc", pc, 16'h0003);
			chk("fmul high", 16'(dbg), n ? 16'h00bf : 16'h0040);
			sel = 5'h00;
			step(1);
			chk("fmul low", 16'(dbg), 16'h0080);
		end
	endtask : t_fmul
	task automatic t_call;
		boot(ldi(4'he, 8'h20), ldi(4'hf, 8'h00), ins(OP_IND_CALL, 5'h00, 5'h00));
		pm.mem[3] = ldi(4'he, 8'h40);
		pm.mem[4] = ins(OP_IND_JUMP, 5'h00, 5'h00);
		pm.mem[32] = ins(OP_RETURN, 5'h00, 5'h00);
		step(4);
		chk("call pc", pc, 16'h0020);
		step(1);
		chk("call busy", 16'(busy), 16'h0000);
		step(1);
		chk("return pc", pc, 16'h0003);
		step(5);
		chk("jump pc", pc, 16'h0040);
		step(1);
		chk("jump busy", 16'(busy), 16'h0000);
		chk("jump flags", 16'(fl), 16'(FLAGS_RST));
	endtask : t_call
	initial
	begin
		step(6);
		t_branch;
		t_skip;
		t_flags;
		t_fmul;
		t_call;
		test_done;
	end
	initial
	begin
		#80000;
		fail_count++;
		test_done;
	end
endmodule : branch_skip_compare_exec_bench
